// ==== ident_pkg.sv ====
/*
  Constants shared by the identification register bank: register
  offsets, field positions, fixed configuration codes and reset values.
  Assumes a 12-bit APB byte address with every register on a word.
*/
package ident_pkg;

  // byte addresses of the identification registers
  localparam logic [11:0] OFF_IDENT_PRODUCT_LOW       = 12'hFE0;
  localparam logic [11:0] OFF_IDENT_MAKER_PRODUCT_HIGH = 12'hFE4;
  localparam logic [11:0] OFF_IDENT_REVISION_MAKER_HIGH = 12'hFE8;
  localparam logic [11:0] OFF_IDENT_BUILD_OPTIONS      = 12'hFEC;
  localparam logic [11:0] OFF_CELL_IDENT_BYTE0         = 12'hFF0;
  localparam logic [11:0] OFF_CELL_IDENT_BYTE1         = 12'hFF4;
  localparam logic [11:0] OFF_CELL_IDENT_BYTE2         = 12'hFF8;
  localparam logic [11:0] OFF_CELL_IDENT_BYTE3         = 12'hFFC;

  // bank control and status words
  localparam logic [11:0] OFF_BANK_CONTROL = 12'hFD0;
  localparam logic [11:0] OFF_BANK_STATUS  = 12'hFD4;

  // combined identifier field positions
  localparam int PRODUCT_LSB  = 0;
  localparam int MAKER_LSB    = 12;
  localparam int REVISION_LSB = 20;
  localparam int OPTIONS_LSB  = 24;

  // build option byte layout
  localparam int OPT_REQ_BIT     = 7;
  localparam int OPT_WIDTH_LSB   = 4;
  localparam int OPT_MASTERS_BIT = 3;
  localparam int OPT_CHAN_LSB    = 0;

  // fixed build option codes of this controller, and the largest width and channel encodings
  localparam logic       REQ_CODE_16      = 1'h0;
  localparam logic [2:0] WIDTH_CODE_32    = 3'h0;
  localparam logic       MASTERS_CODE_TWO = 1'h1;
  localparam logic [2:0] WIDTH_CODE_MAX   = 3'h5;
  localparam logic [2:0] CHAN_CODE_MAX    = 3'h4;

  // control word bits
  localparam int CTRL_STRICT_BIT = 0;
  localparam int CTRL_CLEAR_BIT  = 1;

  // values after reset, and the count ceiling
  localparam logic       STRICT_RESET = 1'h0;
  localparam logic [7:0] COUNT_RESET  = 8'h00;
  localparam logic [7:0] COUNT_MAX    = 8'hFF;

  // bus answer phases
  typedef enum logic {
    PHASE_IDLE,
    PHASE_ANSWER
  } bus_phase_type;

endpackage

// ==== ident_word_pack.sv ====
/*
  Assembles the combined 32-bit peripheral identifier from its fields.
  Purely combinational; the parent supplies constant codes.
*/
`timescale 1ns/1ps
module ident_word_pack
  import ident_pkg::*;
#(
  parameter logic [11:0] PRODUCT_CODE = 12'h3A5,
  parameter logic [7:0]  MAKER_CODE   = 8'h6C,
  parameter logic [3:0]  REVISION     = 4'h2,
  parameter logic [2:0]  CHAN_CODE    = 3'h1
) (
  // combined identifier
  output wire logic [31:0] ident_word
);

  logic [7:0] options;

  // build options byte, fixed by this build
  assign options[OPT_REQ_BIT]                    = REQ_CODE_16;
  assign options[OPT_WIDTH_LSB +: 3]             = WIDTH_CODE_32;
  assign options[OPT_MASTERS_BIT]                = MASTERS_CODE_TWO;
  assign options[OPT_CHAN_LSB +: 3]              = CHAN_CODE;

  // field packing into the conceptual word
  assign ident_word[PRODUCT_LSB +: 12]  = PRODUCT_CODE;
  assign ident_word[MAKER_LSB +: 8]     = MAKER_CODE;
  assign ident_word[REVISION_LSB +: 4]  = REVISION;
  assign ident_word[OPTIONS_LSB +: 8]   = options;

endmodule

// ==== ident_byte_pick.sv ====
/*
  Decodes one group of four consecutive identification byte registers
  and picks the byte of the group word that the address names.
  Assumes a group base aligned to sixteen bytes.
*/
`timescale 1ns/1ps
module ident_byte_pick #(
  parameter logic [11:0] BASE = 12'hFE0
) (
  // request address and group word
  input  wire logic [11:0] addr,
  input  wire logic [31:0] word,
  // decode result
  output wire logic        hit,
  output wire logic [7:0]  byte_out
);

  // group spans sixteen bytes, only word-aligned addresses match
  assign hit      = (addr[11:4] == BASE[11:4]) && (addr[1:0] == 2'h0);
  // register n returns bits 8n+7:8n
  assign byte_out = word[{addr[3:2], 3'h0} +: 8];

endmodule

// ==== ident_bank.sv ====
/*
  Identification register bank of the DMA controller with an APB slave.
  Holds the peripheral and cell identification bytes, plus a control
  word and a status word that counts writes aimed at the fixed bytes.
  Assumes APB signals come from logic on ref_clk; no synchroniser.
*/
`timescale 1ns/1ps
module ident_bank
  import ident_pkg::*;
#(
  parameter logic [11:0] PRODUCT_CODE = 12'h3A5,        // arbitrary value
  parameter logic [7:0]  MAKER_CODE   = 8'h6C,          // arbitrary value
  parameter logic [3:0]  REVISION     = 4'h2,           // arbitrary value
  parameter logic [31:0] CELL_IDENT   = 32'h5AC3_9E17,  // arbitrary value
  parameter logic [2:0]  CHAN_CODE    = 3'h1
) (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset,
  // apb request
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  // apb answer
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr
);

  // configuration codes the encodings cannot express
  if (CHAN_CODE > CHAN_CODE_MAX) begin : bad_chan_code
    $error("channel code above the largest encoding");
  end
  if (WIDTH_CODE_32 > WIDTH_CODE_MAX) begin : bad_width_code
    $error("bus width code above the largest encoding");
  end

  logic [31:0]   periph_word;
  logic [31:0]   cell_word;
  logic          periph_hit;
  logic          cell_hit;
  logic [7:0]    periph_byte;
  logic [7:0]    cell_byte;
  logic          ctrl_hit;
  logic          stat_hit;
  logic          ident_hit;
  logic          mapped;
  logic          setup_phase;
  logic          access_done;
  logic [31:0]   rd_next;
  logic          err_next;
  logic [31:0]   prdata_reg;
  logic          pready_reg;
  logic          pslverr_reg;
  bus_phase_type phase_reg;
  bus_phase_type phase_next;
  logic          wr_ctrl_reg;
  logic          wr_ident_reg;
  logic          strict_reg;
  logic [7:0]    count_reg;
  logic [7:0]    count_next;
  logic          ctrl_write;
  logic          ident_write;

  // fixed identifier words, no storage behind them
  ident_word_pack #(
    .PRODUCT_CODE (PRODUCT_CODE),
    .MAKER_CODE   (MAKER_CODE),
    .REVISION     (REVISION),
    .CHAN_CODE    (CHAN_CODE)
  ) u_word_pack (
    .ident_word (periph_word)
  );

  assign cell_word = CELL_IDENT;

  // peripheral identification bytes
  ident_byte_pick #(
    .BASE (OFF_IDENT_PRODUCT_LOW)
  ) u_periph_pick (
    .addr     (paddr),
    .word     (periph_word),
    .hit      (periph_hit),
    .byte_out (periph_byte)
  );

  // cell identification bytes
  ident_byte_pick #(
    .BASE (OFF_CELL_IDENT_BYTE0)
  ) u_cell_pick (
    .addr     (paddr),
    .word     (cell_word),
    .hit      (cell_hit),
    .byte_out (cell_byte)
  );

  // address decode, taken in the setup cycle
  assign ctrl_hit    = (paddr == OFF_BANK_CONTROL);
  assign stat_hit    = (paddr == OFF_BANK_STATUS);
  assign ident_hit   = periph_hit || cell_hit;
  assign mapped      = ident_hit || ctrl_hit || stat_hit;
  assign setup_phase = psel && !penable;
  assign access_done = psel && penable && pready_reg;

  // read data of the addressed word, bytes zero-extended
  always_comb begin
    rd_next = 32'h0000_0000;
    if (pwrite) begin
      rd_next = 32'h0000_0000;
    end else if (periph_hit) begin
      rd_next = {24'h00_0000, periph_byte};
    end else if (cell_hit) begin
      rd_next = {24'h00_0000, cell_byte};
    end else if (ctrl_hit) begin
      rd_next[CTRL_STRICT_BIT] = strict_reg;
    end else if (stat_hit) begin
      rd_next[7:0] = count_reg;
    end
  end

  // unmapped words fail; fixed bytes refuse writes only in strict mode
  assign err_next = !mapped || (pwrite && ident_hit && strict_reg);

  // answer phase sequencing
  always_comb begin
    case (phase_reg)
      PHASE_IDLE: begin
        phase_next = setup_phase ? PHASE_ANSWER : PHASE_IDLE;
      end
      PHASE_ANSWER: begin
        phase_next = PHASE_IDLE;
      end
      default: begin
        phase_next = PHASE_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      phase_reg <= PHASE_IDLE;
    end else begin
      phase_reg <= phase_next;
    end
  end

  // zero wait states: ready with data in the first access cycle
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end else if (phase_reg == PHASE_IDLE && setup_phase) begin
      pready_reg  <= 1'b1;
      pslverr_reg <= err_next;
      prdata_reg  <= err_next ? 32'h0000_0000 : rd_next;
    end else begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end
  end

  // write target kept from setup so decode glitches cannot retarget
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      wr_ctrl_reg  <= 1'b0;
      wr_ident_reg <= 1'b0;
    end else if (setup_phase) begin
      wr_ctrl_reg  <= pwrite && ctrl_hit;
      wr_ident_reg <= pwrite && ident_hit;
    end
  end

  assign ctrl_write  = access_done && wr_ctrl_reg && pstrb[0];
  assign ident_write = access_done && wr_ident_reg;

  // strict mode bit, the only software-held state
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      strict_reg <= STRICT_RESET;
    end else if (ctrl_write) begin
      strict_reg <= pwdata[CTRL_STRICT_BIT];
    end
  end

  // saturating count of writes aimed at the fixed bytes
  always_comb begin
    count_next = count_reg;
    if (ident_write) begin
      if (count_reg != COUNT_MAX) begin
        count_next = count_reg + 8'h01;
      end
    end else if (ctrl_write && pwdata[CTRL_CLEAR_BIT]) begin
      count_next = COUNT_RESET;
    end
  end

  // the write itself never reaches the identifier words
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      count_reg <= COUNT_RESET;
    end else begin
      count_reg <= count_next;
    end
  end

  // outputs straight from flip-flops
  assign prdata  = prdata_reg;
  assign pready  = pready_reg;
  assign pslverr = pslverr_reg;

  // checking helpers: which byte and group the last setup named
  logic [1:0] sel_reg;
  logic       periph_rd_reg;
  logic       cell_rd_reg;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      sel_reg       <= 2'h0;
      periph_rd_reg <= 1'b0;
      cell_rd_reg   <= 1'b0;
    end else begin
      sel_reg       <= paddr[3:2];
      periph_rd_reg <= setup_phase && !pwrite && periph_hit;
      cell_rd_reg   <= setup_phase && !pwrite && cell_hit;
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  sequence s_setup;
    phase_reg == PHASE_IDLE && psel && !penable;
  endsequence

  sequence s_answer_once;
    pready_reg ##1 !pready_reg;
  endsequence

  // one answer per setup, in the next cycle
  chk_answer_timing:
    assert property (s_setup |=> s_answer_once)
    else $error("ready not raised for exactly one cycle after setup");

  chk_periph_byte:
    assert property (periph_rd_reg |->
      pready_reg && !pslverr_reg && prdata_reg[7:0] == periph_word[{sel_reg, 3'h0} +: 8])
    else $error("identifier byte read returned wrong value");

  chk_cell_byte:
    assert property (cell_rd_reg |->
      pready_reg && !pslverr_reg && prdata_reg[7:0] == cell_word[{sel_reg, 3'h0} +: 8])
    else $error("cell byte read returned wrong value");

  chk_upper_zero:
    assert property ((periph_rd_reg || cell_rd_reg) |-> prdata_reg[31:8] == 24'h00_0000)
    else $error("identifier read has upper bits set");

  chk_words_fixed:
    assert property (ident_write |=> $stable(periph_word) && $stable(cell_word))
    else $error("identifier word changed after a write");

  chk_write_refused:
    assert property (s_setup and (pwrite && ident_hit) |=> pready_reg && pslverr_reg == $past(strict_reg))
    else $error("write to fixed byte answered wrongly");

  chk_count_step:
    assert property (ident_write && count_reg != COUNT_MAX |=> count_reg == $past(count_reg) + 8'h01)
    else $error("refused write count did not advance");

  chk_unmapped_err:
    assert property (s_setup and !mapped |=> pslverr_reg && prdata_reg == 32'h0000_0000)
    else $error("unmapped access not flagged");

  chk_product_field:
    assert property (periph_word[PRODUCT_LSB +: 12] == PRODUCT_CODE && periph_word[MAKER_LSB +: 8] == MAKER_CODE)
    else $error("product or maker field misplaced");

  chk_revision_field:
    assert property (periph_word[REVISION_LSB +: 4] == REVISION)
    else $error("revision field misplaced");

  chk_options_byte:
    assert property (periph_word[OPTIONS_LSB +: 8] ==
      {REQ_CODE_16, WIDTH_CODE_32, MASTERS_CODE_TWO, CHAN_CODE})
    else $error("build options byte wrong");

  chk_req_bit:
    assert property (periph_word[OPTIONS_LSB + OPT_REQ_BIT] == 1'b0)
    else $error("requestor count bit not zero");

  chk_width_code:
    assert property (periph_word[OPTIONS_LSB + OPT_WIDTH_LSB +: 3] == 3'h0)
    else $error("bus width code not 000");

  chk_master_bit:
    assert property (periph_word[OPTIONS_LSB + OPT_MASTERS_BIT] == 1'b1)
    else $error("master count bit not one");

  chk_chan_code:
    assert property (periph_word[OPTIONS_LSB + OPT_CHAN_LSB +: 3] <= CHAN_CODE_MAX)
    else $error("channel code out of range");

  // answer outputs rest at zero outside the ready cycle
  chk_idle_quiet:
    assert property (!pready_reg |-> !pslverr_reg && prdata_reg == 32'h0000_0000)
    else $error("answer outputs not zero outside the ready cycle");

  // identification reads succeed whatever the strict bit says
  chk_ident_read_ok:
    assert property (s_setup and (!pwrite && ident_hit) |=> pready_reg && !pslverr_reg)
    else $error("identification read answered with an error");

  // a word address with low bits set names no register
  chk_misaligned_err:
    assert property (s_setup and (paddr[1:0] != 2'h0) |=> pready_reg && pslverr_reg)
    else $error("misaligned access not refused");

  // strict bit follows the accepted control write
  chk_strict_load:
    assert property (ctrl_write |=> strict_reg == $past(pwdata[CTRL_STRICT_BIT]))
    else $error("strict bit not loaded from the control write");

  // clear request empties the refused count
  chk_count_clear:
    assert property (ctrl_write && pwdata[CTRL_CLEAR_BIT] && !ident_write |=> count_reg == COUNT_RESET)
    else $error("refused count not cleared");

  // count saturates instead of wrapping to zero
  chk_count_ceiling:
    assert property (ident_write && count_reg == COUNT_MAX |=> count_reg == COUNT_MAX)
    else $error("refused count wrapped past its ceiling");

  // nothing but the two write kinds moves the count
  chk_count_quiet:
    assert property (!ident_write && !ctrl_write |=> $stable(count_reg))
    else $error("refused count changed without a write");

endmodule

// ==== testbench.sv ====
/*
  Self-checking bench for the identification register bank.
  Assumes the bank answers an APB setup cycle with pready in the first
  access cycle, and that its assertions live inside the design files.
*/
`timescale 1ns/1ps
module testbench;
  import ident_pkg::*;

  // own identity values handed to the bank
  localparam logic [11:0] PRODUCT_VAL  = 12'h2B7;        // arbitrary value
  localparam logic [7:0]  MAKER_VAL    = 8'h5E;          // arbitrary value
  localparam logic [3:0]  REVISION_VAL = 4'h3;           // arbitrary value
  localparam logic [31:0] CELL_VAL     = 32'h6D1E_4A29;  // arbitrary value
  localparam logic [2:0]  CHAN_VAL     = 3'h4;           // largest channel code
  localparam logic [7:0]  OPTIONS_VAL  = {1'b0, 3'b000, 1'b1, CHAN_VAL};
  localparam logic [31:0] IDENT_VAL    = {OPTIONS_VAL, REVISION_VAL, MAKER_VAL, PRODUCT_VAL};
  localparam int          LIMIT        = 5000;

  typedef struct packed {
    logic [11:0] addr;
    logic        wr;
    logic [31:0] wdata;
    logic [3:0]  strb;
    logic        err;
    logic [31:0] rdata;
  } row_type;

  // clock, reset and bus
  logic        ref_clk;
  logic        reset;
  logic [11:0] paddr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  wire  [31:0] prdata;
  wire         pready;
  wire         pslverr;
  int          bad_count;
  int          checks_done;
  int          cycles;
  row_type     rows [25];
  logic [31:0] rd;
  logic [31:0] word;
  logic        er;

  ident_bank #(
    .PRODUCT_CODE (PRODUCT_VAL),
    .MAKER_CODE   (MAKER_VAL),
    .REVISION     (REVISION_VAL),
    .CELL_IDENT   (CELL_VAL),
    .CHAN_CODE    (CHAN_VAL)
  ) i_dut (
    .ref_clk (ref_clk),
    .reset   (reset),
    .paddr   (paddr),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .pwdata  (pwdata),
    .pstrb   (pstrb),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr)
  );

  // 25 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // hang guard, far above the 640 or so cycles the run needs
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      bad_count++;
      $display("ERROR at %0t: run did not finish", $time);
      final_report();
    end
  end

  task automatic compare(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // one transfer, entered right after an edge; left asserted so a
  // second transfer can follow at once without a double assignment
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d, input logic [3:0] s,
                     output logic [31:0] rdat, output logic err);
    int n;
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1);
    rdat = prdata;
    err  = pslverr;
    // zero wait states: the answer comes in the first access cycle
    compare(n, 1, "access cycles");
  endtask

  // release the bus; the answer must have dropped after one cycle
  task automatic idle();
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
    compare({31'h0, pready}, 32'h0, "ready held too long");
  endtask

  initial begin
    reset = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h0; pwdata = 32'h0; pstrb = 4'h0;
    bad_count = 0; checks_done = 0; cycles = 0;
    // address, write, data, strobes, error, read data
    rows = '{
      '{12'hFE0, 0, 0, 4'hF, 0, {24'h0, IDENT_VAL[7:0]}},
      '{12'hFE4, 0, 0, 4'hF, 0, {24'h0, IDENT_VAL[15:8]}},
      '{12'hFE8, 0, 0, 4'hF, 0, {24'h0, IDENT_VAL[23:16]}},
      '{12'hFEC, 0, 0, 4'hF, 0, {24'h0, IDENT_VAL[31:24]}},
      '{12'hFF0, 0, 0, 4'hF, 0, {24'h0, CELL_VAL[7:0]}},
      '{12'hFF4, 0, 0, 4'hF, 0, {24'h0, CELL_VAL[15:8]}},
      '{12'hFF8, 0, 0, 4'hF, 0, {24'h0, CELL_VAL[23:16]}},
      '{12'hFFC, 0, 0, 4'hF, 0, {24'h0, CELL_VAL[31:24]}},
      '{12'hFE0, 1, 32'hFFFF_FFFF, 4'hF, 0, 0},
      '{12'hFFC, 1, 32'h0000_0000, 4'hF, 0, 0},
      '{12'hFD0, 1, 32'h0000_0001, 4'hE, 0, 0},
      '{12'hFD0, 0, 0, 4'hF, 0, 32'h0},
      '{12'hFD0, 1, 32'h0000_0001, 4'h1, 0, 0},
      '{12'hFD0, 0, 0, 4'hF, 0, 32'h1},
      '{12'hFEC, 1, 32'h0000_00FF, 4'hF, 1, 0},
      '{12'hFEC, 0, 0, 4'hF, 0, {24'h0, IDENT_VAL[31:24]}},
      '{12'hFD4, 0, 0, 4'hF, 0, 32'h3},
      '{12'hFE2, 0, 0, 4'hF, 1, 32'h0},
      '{12'h100, 0, 0, 4'hF, 1, 32'h0},
      '{12'hFD0, 1, 32'h0000_0002, 4'h1, 0, 0},
      '{12'hFD4, 0, 0, 4'hF, 0, 32'h0},
      '{12'hFD0, 0, 0, 4'hF, 0, 32'h0},
      '{12'hFE0, 0, 0, 4'hF, 0, {24'h0, IDENT_VAL[7:0]}},
      '{12'hFF0, 1, 32'h1234_5678, 4'hF, 0, 0},
      '{12'hFD4, 0, 0, 4'hF, 0, 32'h1}
    };
    repeat (12) @(posedge ref_clk);
    compare(prdata | {30'h0, pready, pslverr}, 32'h0, "outputs in reset");
    reset <= 1'b0;
    @(posedge ref_clk);
    // table of ordinary transfers
    for (int i = 0; i < $size(rows); i++) begin
      apb(rows[i].addr, rows[i].wr, rows[i].wdata, rows[i].strb, rd, er);
      idle();
      compare({31'h0, er}, {31'h0, rows[i].err}, "error flag");
      if (!rows[i].wr) compare(rd, rows[i].rdata, "read data");
    end
    // back-to-back group reads, assembled into the combined words
    for (int g = 0; g < 2; g++) begin
      for (int n = 0; n < 4; n++) begin
        apb(12'hFE0 + 12'(g * 16 + n * 4), 1'b0, 32'h0, 4'hF, rd, er);
        word[n*8 +: 8] = rd[7:0];
        compare({rd[31:8], 7'h0, er}, 32'h0, "upper bits or error");
      end
      idle();
      compare(word, g == 0 ? IDENT_VAL : CELL_VAL, "combined word");
      if (g == 0) compare({28'h0, word[23:20]}, {28'h0, REVISION_VAL}, "revision field");
    end
    // reset in mid-run clears strict mode and the refused count
    apb(12'hFD0, 1'b1, 32'h1, 4'hF, rd, er);
    apb(12'hFE4, 1'b1, 32'h0, 4'hF, rd, er);
    idle();
    compare({31'h0, er}, 32'h1, "strict write error");
    reset <= 1'b1;
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    apb(12'hFD4, 1'b0, 32'h0, 4'hF, rd, er);
    compare(rd, 32'h0, "count after reset");
    apb(12'hFD0, 1'b0, 32'h0, 4'hF, rd, er);
    compare(rd, 32'h0, "strict after reset");
    apb(12'hFE4, 1'b0, 32'h0, 4'hF, rd, er);
    idle();
    compare(rd, {24'h0, IDENT_VAL[15:8]}, "byte after reset");
    // more refused writes than the count holds; it must stop at its ceiling
    for (int i = 0; i < 256; i++) begin
      apb(12'hFE0, 1'b1, 32'h0, 4'hF, rd, er);
    end
    apb(12'hFD4, 1'b0, 32'h0, 4'hF, rd, er);
    compare(rd, {24'h0, COUNT_MAX}, "count at ceiling");
    apb(12'hFE0, 1'b0, 32'h0, 4'hF, rd, er);
    idle();
    compare(rd, {24'h0, IDENT_VAL[7:0]}, "byte after many writes");
    final_report();
  end
endmodule
